// ==== logic/spi_slave_controller.v ====
// spi slave controller: serial shifters, character fifos, status and dma count capture
`timescale 1ns/1ns
`include "spi_slave_defines.vh"
module spi_slave_controller #(
    parameter CNT_W = `SPI_RXCNT_BITS
) (
    // clock, reset, enable
    input wire i_ref_clk,
    input wire i_nrst,
    input wire i_ce,
    // serial pins
    input wire i_sclk,
    input wire i_mosi,
    input wire i_slave_select_n,
    output reg o_miso,
    output reg o_miso_oe,
    // configuration
    input wire [2:0] i_serial_mode_select,
    input wire i_master_select_bit,
    input wire i_clock_polarity_bit,
    input wire i_clock_phase_bit,
    input wire i_bit_order_bit,
    input wire i_underrun_repeat_bit,
    // software data port
    input wire i_data_wr,
    input wire [7:0] i_data_wdata,
    input wire i_data_rd,
    output reg [7:0] o_data_rdata,
    output reg o_data_rvalid,
    // dma channels
    input wire i_tx_dma_en,
    input wire i_tx_dma_wr,
    input wire [7:0] i_tx_dma_wdata,
    input wire i_rx_dma_en,
    input wire i_rx_dma_rd,
    input wire i_rx_dma_reset,
    input wire i_rx_buf_load,
    input wire i_rx_buf_b_active,
    input wire [CNT_W-1:0] i_rx_dma_count,
    // status
    output reg o_rx_valid_flag,
    output reg o_rx_overflow_flag,
    output reg o_tx_space_flag,
    output reg o_tx_idle_flag,
    output reg o_rx_overrun_irq,
    output reg o_tx_underrun_irq,
    output reg o_dma_rx_error,
    output reg [2:0] o_select_edge_record,
    output reg [CNT_W-1:0] o_saved_rx_count
);
    // ********************************
    // helpers
    // ********************************
    function [7:0] shift_in;
        input [7:0] cur;
        input bit_in;
        input lsb_first;
        begin
            shift_in = lsb_first ? {bit_in, cur[7:1]} : {cur[6:0], bit_in};
        end
    endfunction

    function out_bit;
        input [7:0] sh;
        input lsb_first;
        begin
            out_bit = lsb_first ? sh[0] : sh[7];
        end
    endfunction

    // ********************************
    // pin synchronisation and edges
    // ********************************
    wire sclk_s;
    wire mosi_s;
    wire ss_n_s;
    pin_sync #(.WIDTH(3)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_async({i_sclk, i_mosi, i_slave_select_n}),
        .o_sync({sclk_s, mosi_s, ss_n_s})
    );

    reg sck_d_r;
    reg ss_n_d_r;
    reg sel_d_r;

    wire slave_en = (i_serial_mode_select == `SPI_MODE_SLAVE) && !i_master_select_bit;
    wire sel_act = slave_en && !ss_n_s;
    wire ss_fall = sel_act && !sel_d_r;
    wire ss_rise = slave_en && ss_n_s && !ss_n_d_r;
    // normalised clock: leading edge is always a rise
    wire sck_n = sclk_s ^ i_clock_polarity_bit;
    wire lead_edge = sck_n && !sck_d_r;
    wire trail_edge = !sck_n && sck_d_r;
    // edges count only while selected, and not in the selecting cycle
    wire sample_edge = sel_act && !ss_fall &&
        (i_clock_phase_bit ? trail_edge : lead_edge);
    wire shift_edge = sel_act && !ss_fall &&
        (i_clock_phase_bit ? lead_edge : trail_edge);

    // ********************************
    // fifos
    // ********************************
    wire tx_full;
    wire tx_empty;
    wire [7:0] tx_head;
    wire rx_full;
    wire rx_empty;
    wire [7:0] rx_head;
    reg tx_pop;
    reg rx_push;
    reg [7:0] rx_byte;

    wire tx_wr = i_tx_dma_en ? i_tx_dma_wr : i_data_wr;
    wire [7:0] tx_wdata = i_tx_dma_en ? i_tx_dma_wdata : i_data_wdata;
    wire rx_rd = i_rx_dma_en ? i_rx_dma_rd : i_data_rd;
    wire tx_push = tx_wr && !tx_full;

    byte_fifo #(.WIDTH(`SPI_CHAR_BITS), .DEPTH(`SPI_FIFO_DEPTH), .AW(2)) u_tx_fifo (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_push(tx_push),
        .i_data(tx_wdata),
        .i_pop(tx_pop),
        .o_head(tx_head),
        .o_full(tx_full),
        .o_empty(tx_empty)
    );

    byte_fifo #(.WIDTH(`SPI_CHAR_BITS), .DEPTH(`SPI_FIFO_DEPTH), .AW(2)) u_rx_fifo (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_push(rx_push),
        .i_data(rx_byte),
        .i_pop(rx_rd),
        .o_head(rx_head),
        .o_full(rx_full),
        .o_empty(rx_empty)
    );

    // ********************************
    // serializer state
    // ********************************
    reg [7:0] tx_sh_r;
    reg [7:0] tx_sh_nxt;
    reg [7:0] rx_sh_r;
    reg [7:0] rx_sh_nxt;
    reg [2:0] bit_cnt_r;
    reg [2:0] bit_cnt_nxt;
    reg need_load_r;
    reg need_load_nxt;
    reg pad_pend_r;
    reg pad_pend_nxt;
    reg tx_busy_r;
    reg tx_busy_nxt;
    reg [7:0] last_tx_r;
    reg [7:0] last_tx_nxt;
    reg rpt_r;
    reg underrun;
    reg overrun;
    reg loading;
    reg [7:0] load_byte;

    // a change of the repeat choice waits until nothing is queued or shifting
    wire [7:0] pad_byte = rpt_r ? last_tx_r : `SPI_BUSY_TOKEN;

    always @* begin
        tx_sh_nxt = tx_sh_r;
        rx_sh_nxt = rx_sh_r;
        bit_cnt_nxt = bit_cnt_r;
        need_load_nxt = need_load_r;
        tx_busy_nxt = tx_busy_r;
        last_tx_nxt = last_tx_r;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_byte = shift_in(rx_sh_r, mosi_s, i_bit_order_bit);
        underrun = 1'b0;
        overrun = 1'b0;
        load_byte = pad_byte;
        // pin-facing bytes load at select for phase 0, else at the next shift edge
        loading = (ss_fall && !i_clock_phase_bit) || (shift_edge && need_load_r);
        if (pad_pend_r) begin
            load_byte = pad_byte;
        end else if (!tx_empty) begin
            load_byte = tx_head;
        end
        pad_pend_nxt = pad_pend_r && !(loading);
        if (loading && !pad_pend_r) begin
            if (!tx_empty) begin
                tx_pop = 1'b1;
                tx_busy_nxt = 1'b1;
            end else begin
                underrun = 1'b1;
            end
        end
        // data into an empty fifo with no fifo byte shifting queues one padding byte; set wins over consume
        if (tx_push && tx_empty && !tx_busy_r) begin
            pad_pend_nxt = 1'b1;
        end
        if (ss_fall) begin
            rx_sh_nxt = `SPI_RST_BYTE;
            bit_cnt_nxt = 3'h0;
            need_load_nxt = i_clock_phase_bit;
            tx_sh_nxt = loading ? load_byte : `SPI_RST_BYTE;
        end else if (sel_act) begin
            if (shift_edge) begin
                if (need_load_r) begin
                    tx_sh_nxt = load_byte;
                    need_load_nxt = 1'b0;
                end else begin
                    tx_sh_nxt = shift_in(tx_sh_r, 1'b0, i_bit_order_bit);
                end
            end
            if (sample_edge) begin
                rx_sh_nxt = rx_byte;
                bit_cnt_nxt = bit_cnt_r + 3'h1;
                if (bit_cnt_r == `SPI_LAST_BIT) begin
                    need_load_nxt = 1'b1;
                    tx_busy_nxt = 1'b0;
                    if (rx_full) begin
                        overrun = 1'b1;
                    end else begin
                        rx_push = 1'b1;
                    end
                end
            end
        end else begin
            // a frame cut short leaves nothing in flight
            tx_busy_nxt = 1'b0;
        end
        if (loading) begin
            last_tx_nxt = load_byte;
        end
    end

    // ********************************
    // sequential serial and status logic
    // ********************************
    reg ovf_pend_r;
    reg rec_done_r;

    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            sck_d_r <= 1'b0;
            ss_n_d_r <= 1'b1;
            sel_d_r <= 1'b0;
            tx_sh_r <= `SPI_RST_BYTE;
            rx_sh_r <= `SPI_RST_BYTE;
            bit_cnt_r <= 3'h0;
            need_load_r <= 1'b0;
            pad_pend_r <= 1'b0;
            tx_busy_r <= 1'b0;
            last_tx_r <= `SPI_RST_BYTE;
            rpt_r <= 1'b0;
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
            o_data_rdata <= `SPI_RST_BYTE;
            o_data_rvalid <= 1'b0;
            o_rx_valid_flag <= 1'b0;
            o_rx_overflow_flag <= 1'b0;
            o_tx_space_flag <= 1'b1;
            o_tx_idle_flag <= 1'b1;
            o_rx_overrun_irq <= 1'b0;
            o_tx_underrun_irq <= 1'b0;
            ovf_pend_r <= 1'b0;
            o_dma_rx_error <= 1'b0;
            rec_done_r <= 1'b0;
            o_select_edge_record <= `SER_RST_VAL;
            o_saved_rx_count <= {CNT_W{1'b0}};
        end else if (i_ce) begin
            sck_d_r <= sck_n;
            ss_n_d_r <= ss_n_s;
            sel_d_r <= sel_act;
            tx_sh_r <= tx_sh_nxt;
            rx_sh_r <= rx_sh_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            need_load_r <= need_load_nxt;
            pad_pend_r <= pad_pend_nxt;
            tx_busy_r <= tx_busy_nxt;
            last_tx_r <= last_tx_nxt;
            if (tx_empty && !tx_busy_r && !pad_pend_r) begin
                rpt_r <= i_underrun_repeat_bit;
            end
            // miso follows the next shift value to save a cycle of latency
            o_miso <= sel_act ? out_bit(tx_sh_nxt, i_bit_order_bit) : 1'b0;
            o_miso_oe <= sel_act;
            o_data_rvalid <= rx_rd && !rx_empty;
            if (rx_rd && !rx_empty) begin
                o_data_rdata <= rx_head;
            end
            // registered level: drops one cycle after the last entry is popped
            o_rx_valid_flag <= !rx_empty || rx_push;
            // set on drop wins over the clear by a data read
            if (overrun) begin
                o_rx_overflow_flag <= 1'b1;
            end else if (rx_rd) begin
                o_rx_overflow_flag <= 1'b0;
            end
            o_rx_overrun_irq <= overrun;
            o_tx_underrun_irq <= underrun;
            o_tx_space_flag <= !tx_full || tx_pop;
            o_tx_idle_flag <= tx_empty && !tx_busy_nxt && !tx_push && !pad_pend_nxt;
            // the dma sees the overrun only once the fifo has drained
            if (overrun) begin
                ovf_pend_r <= 1'b1;
            end else if (ovf_pend_r && rx_empty) begin
                ovf_pend_r <= 1'b0;
            end
            if (ovf_pend_r && rx_empty && !overrun) begin
                o_dma_rx_error <= 1'b1;
            end else if (i_rx_dma_reset || i_rx_buf_load) begin
                o_dma_rx_error <= 1'b0;
            end
            // count capture: first rise after a load saves, later ones only mark
            if (ss_rise && i_rx_dma_en) begin
                if (!rec_done_r) begin
                    rec_done_r <= 1'b1;
                    o_saved_rx_count <= i_rx_dma_count;
                    o_select_edge_record[`SER_SAVED_POS] <= 1'b1;
                    o_select_edge_record[`SER_BUF_B_POS] <= i_rx_buf_b_active;
                end else begin
                    o_select_edge_record[`SER_AGAIN_POS] <= 1'b1;
                end
            end else if (i_rx_buf_load || i_rx_dma_reset) begin
                rec_done_r <= 1'b0;
                o_select_edge_record <= `SER_RST_VAL;
            end
        end
    end
endmodule // spi_slave_controller

// ==== logic/spi_slave_defines.vh ====
// constants for the spi slave controller: modes, tokens, depths and field positions
//
// Behaviour
// - slave only when mode two, master clear
// - polarity, phase and bit order shape frames
// - drive miso only while select asserted
// - select falling edge resets receive shifter; transmit loads in phase 0, resets in phase 1
// - transmit and receive fifos four deep
// - data write pushes, data read pops
// - dma channels replace software fifo accesses
// - store received bytes, flag while fifo holds
// - byte into full fifo dropped, overflow flagged
// - dma error shown only after fifo drained
// - dma error cleared by reset or load
// - each received byte sends one fifo byte
// - empty fifo underrun sends last or 0xFF
// - write into idle transmitter clears idle flag
// - space flag clears full, sets on shifting
// - idle when fifo empty and last shifted
// - data into empty fifo preceded by padding; not while a fifo byte is shifting
// - select rise saves active dma receive count
// - only first rise after load saves count
// - three bit record of save and rises
// - phase bit selects first or second edge
// - polarity bit selects rising or falling lead
// - repeat bit picks token, applied when idle
`ifndef SPI_SLAVE_DEFINES_VH
`define SPI_SLAVE_DEFINES_VH

// ********************************
// mode and data constants
// ********************************
`define SPI_MODE_SLAVE 3'h2
`define SPI_BUSY_TOKEN 8'hFF
`define SPI_FIFO_DEPTH 4
`define SPI_CHAR_BITS 8
`define SPI_RXCNT_BITS 16
`define SPI_LAST_BIT 3'h7

// ********************************
// select edge record field positions and reset values
// ********************************
`define SER_SAVED_POS 0
`define SER_AGAIN_POS 1
`define SER_BUF_B_POS 2
`define SER_RST_VAL 3'h0
`define SPI_RST_BYTE 8'h00

`endif

// ==== logic/pin_sync.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter WIDTH = 3
) (
    // clock, reset, enable
    input wire i_ref_clk,
    input wire i_nrst,
    input wire i_ce,
    // asynchronous in, synchronised out
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_r;

    // meta_r feeds only the second stage
    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            meta_r <= {WIDTH{1'b1}};
            o_sync <= {WIDTH{1'b1}};
        end else if (i_ce) begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule // pin_sync

// ==== logic/byte_fifo.v ====
// small synchronous fifo holding characters
`timescale 1ns/1ns
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock, reset, enable
    input wire i_ref_clk,
    input wire i_nrst,
    input wire i_ce,
    // write side
    input wire i_push,
    input wire [WIDTH-1:0] i_data,
    // read side
    input wire i_pop,
    output wire [WIDTH-1:0] o_head,
    // state
    output wire o_full,
    output wire o_empty
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;

    wire do_push = i_push && !o_full;
    wire do_pop = i_pop && !o_empty;

    assign o_full = (count_r == DEPTH[AW:0]);
    assign o_empty = (count_r == {(AW+1){1'b0}});
    assign o_head = mem_r[rd_ptr_r];

    // ********************************
    // pointers and storage
    // ********************************
    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else if (i_ce) begin
            if (do_push) begin
                mem_r[wr_ptr_r] <= i_data;
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_r <= count_r + 1'b1;
            end else if (do_pop && !do_push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // byte_fifo

// ==== tb/spi_slave_controller_monitor.sv ====
// concurrent checks on the spi slave controller ports
`timescale 1ns/1ns
module spi_slave_controller_monitor #(
    parameter CNT_W = 16
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_nrst,
    // inputs watched
    input wire i_slave_select_n,
    input wire [2:0] i_serial_mode_select,
    input wire i_master_select_bit,
    input wire i_data_wr,
    input wire i_data_rd,
    input wire i_tx_dma_wr,
    input wire i_rx_dma_en,
    input wire i_rx_dma_reset,
    input wire i_rx_buf_load,
    // outputs watched
    input wire o_miso_oe,
    input wire o_data_rvalid,
    input wire o_rx_valid_flag,
    input wire o_rx_overflow_flag,
    input wire o_rx_overrun_irq,
    input wire o_tx_idle_flag,
    input wire o_dma_rx_error,
    input wire [2:0] o_select_edge_record,
    input wire [CNT_W-1:0] o_saved_rx_count
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);
    // first read after a gap, so a lagging flag cannot fake a hit
    sequence s_sw_read;
        i_data_rd && !i_rx_dma_en && o_rx_valid_flag && !$past(i_data_rd);
    endsequence
    sequence s_clear_req;
        i_rx_dma_reset || i_rx_buf_load;
    endsequence
    a_oe_mode_gate: assert property ((i_serial_mode_select != 3'h2) [*3] |-> !o_miso_oe)
        else $error("miso driven outside slave mode");
    a_oe_master_gate: assert property (i_master_select_bit [*3] |-> !o_miso_oe)
        else $error("miso driven with master bit set");
    a_oe_select_gate: assert property (i_slave_select_n [*4] |-> !o_miso_oe)
        else $error("miso driven while deselected");
    a_read_answer: assert property (s_sw_read |=> o_data_rvalid)
        else $error("read of filled fifo gave no data");
    a_ovf_on_drop: assert property (o_rx_overrun_irq |-> ##[0:1] o_rx_overflow_flag)
        else $error("dropped byte without overflow flag");
    a_ovf_read_clr: assert property ($past(i_data_rd) && !i_rx_dma_en && o_data_rvalid
        && !o_rx_overrun_irq |-> !o_rx_overflow_flag)
        else $error("overflow flag survived a read");
    a_err_after_drain: assert property ($rose(o_dma_rx_error) |-> !o_rx_valid_flag)
        else $error("dma error shown before drain");
    a_err_clear: assert property (s_clear_req |=> !o_dma_rx_error
        && o_select_edge_record == 3'h0)
        else $error("error or record not cleared");
    a_saved_hold: assert property (o_select_edge_record[0] && !i_rx_buf_load
        |=> $stable(o_saved_rx_count))
        else $error("saved count rewritten");
    a_idle_drop: assert property ($fell(o_tx_idle_flag)
        |-> $past(i_data_wr) || $past(i_tx_dma_wr))
        else $error("idle flag fell without a write");
endmodule // spi_slave_controller_monitor

bind spi_slave_controller spi_slave_controller_monitor #(.CNT_W(CNT_W)) i_mon (
    .i_ref_clk, .i_nrst, .i_slave_select_n, .i_serial_mode_select, .i_master_select_bit,
    .i_data_wr, .i_data_rd, .i_tx_dma_wr, .i_rx_dma_en, .i_rx_dma_reset, .i_rx_buf_load,
    .o_miso_oe, .o_data_rvalid, .o_rx_valid_flag, .o_rx_overflow_flag, .o_rx_overrun_irq,
    .o_tx_idle_flag, .o_dma_rx_error, .o_select_edge_record, .o_saved_rx_count
);

// ==== tb/spi_master_model.sv ====
// behavioural spi master that clocks frames through the slave
`timescale 1ns/1ns
module spi_master_model (
    // slave side
    input wire i_miso,
    input wire i_miso_oe,
    // frame format
    input wire i_cpol,
    input wire i_cpha,
    input wire i_lsb,
    // serial pins
    output reg o_sclk,
    output reg o_mosi,
    output reg o_slave_select_n
);
    reg last = 1'b0;
    integer b;
    initial begin
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        o_slave_select_n = 1'b1;
    end
    // a released miso reads inverted, never as a stale copy
    task grab(inout [7:0] r);
        begin
            r[b] = i_miso_oe ? i_miso : ~last;
            last = r[b];
        end
    endtask
    task sel;
        begin
            o_sclk = i_cpol;
            #400 o_slave_select_n = 1'b0;
            #400;
        end
    endtask
    task desel;
        begin
            #400 o_slave_select_n = 1'b1;
            o_mosi = ~o_mosi;
            #400;
        end
    endtask
    // half period 200 ns keeps the link at 2.5 Mbps; clock stands still between frames
    task xfer(input [7:0] tx, input integer n, output [7:0] rx);
        integer k;
        begin
            rx = 8'h00;
            for (k = 0; k < n; k = k + 1) begin
                b = i_lsb ? k : 7 - k;
                if (!i_cpha) o_mosi = tx[b];
                #200 o_sclk = ~i_cpol;
                if (i_cpha) o_mosi = tx[b];
                else grab(rx);
                #200 o_sclk = i_cpol;
                if (i_cpha) grab(rx);
            end
            #300;
        end
    endtask
endmodule // spi_master_model

// ==== tb/spi_slave_controller_tb.sv ====
// self-checking bench for the spi slave controller
`timescale 1ns/1ns
`include "spi_slave_defines.vh"
module spi_slave_controller_tb;
    reg i_ref_clk = 1'b0;
    reg i_nrst = 1'b0;
    reg i_ce = 1'b1;
    reg [2:0] i_serial_mode_select = 3'h2;
    reg i_master_select_bit = 1'b0, i_clock_polarity_bit = 1'b0, i_clock_phase_bit = 1'b0;
    reg i_bit_order_bit = 1'b0, i_underrun_repeat_bit = 1'b0, i_data_wr = 1'b0;
    reg i_data_rd = 1'b0, i_tx_dma_en = 1'b0, i_tx_dma_wr = 1'b0, i_rx_dma_en = 1'b0;
    reg i_rx_dma_rd = 1'b0, i_rx_dma_reset = 1'b0, i_rx_buf_load = 1'b0;
    reg i_rx_buf_b_active = 1'b0;
    reg [7:0] i_data_wdata = 8'h00;
    reg [15:0] i_rx_dma_count = 16'h0000;
    wire i_sclk, i_mosi, i_slave_select_n, o_miso, o_miso_oe, o_data_rvalid;
    wire o_rx_valid_flag, o_rx_overflow_flag, o_tx_space_flag, o_tx_idle_flag;
    wire o_rx_overrun_irq, o_tx_underrun_irq, o_dma_rx_error;
    wire [7:0] o_data_rdata;
    wire [2:0] o_select_edge_record;
    wire [15:0] o_saved_rx_count;
    integer error_cnt = 0;
    integer num_checks = 0;
    reg und_seen = 1'b0;
    reg [2:0] m;
    reg [7:0] got;
    spi_slave_controller i_spi_slave_controller (
        .i_ref_clk, .i_nrst, .i_ce, .i_sclk, .i_mosi, .i_slave_select_n, .o_miso, .o_miso_oe,
        .i_serial_mode_select, .i_master_select_bit, .i_clock_polarity_bit,
        .i_clock_phase_bit, .i_bit_order_bit, .i_underrun_repeat_bit, .i_data_wr,
        .i_data_wdata, .i_data_rd, .o_data_rdata, .o_data_rvalid, .i_tx_dma_en, .i_tx_dma_wr,
        .i_tx_dma_wdata(i_data_wdata), .i_rx_dma_en, .i_rx_dma_rd, .i_rx_dma_reset,
        .i_rx_buf_load, .i_rx_buf_b_active, .i_rx_dma_count, .o_rx_valid_flag,
        .o_rx_overflow_flag, .o_tx_space_flag, .o_tx_idle_flag, .o_rx_overrun_irq,
        .o_tx_underrun_irq, .o_dma_rx_error, .o_select_edge_record, .o_saved_rx_count
    );
    spi_master_model i_spi_master_model (
        .i_miso(o_miso), .i_miso_oe(o_miso_oe), .i_cpol(i_clock_polarity_bit),
        .i_cpha(i_clock_phase_bit), .i_lsb(i_bit_order_bit), .o_sclk(i_sclk),
        .o_mosi(i_mosi), .o_slave_select_n(i_slave_select_n)
    );
    initial forever #25 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) if (o_tx_underrun_irq) und_seen <= 1'b1;
    // ********************************
    // access tasks
    // ********************************
    task check(input [15:0] g, input [15:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task push(input [7:0] d, input dma);
        begin
            @(negedge i_ref_clk);
            i_data_wdata = d;
            i_data_wr = ~dma;
            i_tx_dma_wr = dma;
            @(negedge i_ref_clk);
            i_data_wr = 1'b0;
            i_tx_dma_wr = 1'b0;
        end
    endtask
    task pop(input [7:0] e);
        begin
            @(negedge i_ref_clk);
            i_data_rd = ~i_rx_dma_en;
            i_rx_dma_rd = i_rx_dma_en;
            @(negedge i_ref_clk);
            i_data_rd = 1'b0;
            i_rx_dma_rd = 1'b0;
            check({15'h0, o_data_rvalid}, 16'h1);
            check({8'h0, o_data_rdata}, {8'h0, e});
        end
    endtask
    task strobe(input rst);
        begin
            @(negedge i_ref_clk);
            i_rx_dma_reset = rst;
            i_rx_buf_load = ~rst;
            @(negedge i_ref_clk);
            i_rx_dma_reset = 1'b0;
            i_rx_buf_load = 1'b0;
        end
    endtask
    task xch(input [7:0] mo, input [7:0] e, input c);
        begin
            i_spi_master_model.xfer(mo, 8, got);
            if (c) check({8'h0, got}, {8'h0, e});
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        error_cnt = error_cnt + 1;
        complete_run;
    end
    // ********************************
    // tests
    // ********************************
    initial begin
        repeat (6) @(negedge i_ref_clk);
        i_nrst = 1'b1;
        check({12'h0, o_tx_space_flag, o_tx_idle_flag, o_rx_valid_flag, o_miso_oe}, 16'hC);
        $display("test reset done");
        i_rx_dma_en = 1'b1;
        i_rx_buf_b_active = 1'b1;
        i_rx_dma_count = 16'h1234;
        strobe(1'b0);
        push(8'hA5, 1'b0);
        push(8'h3C, 1'b0);
        push(8'h5A, 1'b0);
        push(8'hC3, 1'b0);
        @(negedge i_ref_clk);
        check({15'h0, o_tx_idle_flag}, 16'h0);
        check({15'h0, o_tx_space_flag}, 16'h0);
        i_spi_master_model.sel;
        xch(8'h11, `SPI_BUSY_TOKEN, 1'b1);
        check({15'h0, o_tx_space_flag}, 16'h1);
        xch(8'h22, 8'hA5, 1'b1);
        xch(8'h33, 8'h3C, 1'b1);
        xch(8'h44, 8'h5A, 1'b1);
        xch(8'h55, 8'h00, 1'b0);
        i_spi_master_model.desel;
        check({15'h0, o_tx_idle_flag}, 16'h1);
        check({15'h0, und_seen}, 16'h1);
        check({15'h0, o_rx_overflow_flag}, 16'h1);
        check(o_saved_rx_count, 16'h1234);
        check({13'h0, o_select_edge_record}, 16'h5);
        check({15'h0, o_dma_rx_error}, 16'h0);
        pop(8'h11);
        pop(8'h22);
        pop(8'h33);
        pop(8'h44);
        repeat (3) @(negedge i_ref_clk);
        check({15'h0, o_dma_rx_error}, 16'h1);
        i_tx_dma_en = 1'b1;
        i_rx_dma_count = 16'h5678;
        push(8'h96, 1'b1);
        i_spi_master_model.sel;
        xch(8'h01, `SPI_BUSY_TOKEN, 1'b1);
        xch(8'h02, 8'h96, 1'b1);
        i_spi_master_model.desel;
        check({13'h0, o_select_edge_record}, 16'h7);
        check(o_saved_rx_count, 16'h1234);
        strobe(1'b1);
        check({12'h0, o_select_edge_record, o_dma_rx_error}, 16'h0);
        pop(8'h01);
        pop(8'h02);
        @(negedge i_ref_clk);
        check({15'h0, o_rx_valid_flag}, 16'h0);
        i_rx_dma_en = 1'b0;
        i_tx_dma_en = 1'b0;
        $display("test dma and overrun done");
        for (m = 3'h0; m < 3'h4; m = m + 3'h1) begin
            i_clock_polarity_bit = m[1];
            i_clock_phase_bit = m[0];
            i_bit_order_bit = m[0];
            push({6'h0E, m[1:0]}, 1'b0);
            i_spi_master_model.sel;
            xch({6'h30, m[1:0]}, `SPI_BUSY_TOKEN, 1'b1);
            xch(8'h17, {6'h0E, m[1:0]}, 1'b1);
            i_spi_master_model.desel;
            pop({6'h30, m[1:0]});
            pop(8'h17);
        end
        $display("test frame formats done");
        i_clock_polarity_bit = 1'b0;
        i_clock_phase_bit = 1'b0;
        i_bit_order_bit = 1'b0;
        i_underrun_repeat_bit = 1'b1;
        push(8'h96, 1'b0);
        i_spi_master_model.sel;
        xch(8'h00, 8'h00, 1'b0);
        xch(8'h00, 8'h96, 1'b1);
        xch(8'h00, 8'h96, 1'b1);
        i_spi_master_model.desel;
        repeat (3) pop(8'h00);
        i_spi_master_model.sel;
        i_spi_master_model.xfer(8'hF0, 4, got);
        i_spi_master_model.desel;
        i_spi_master_model.sel;
        xch(8'h69, 8'h00, 1'b0);
        i_spi_master_model.desel;
        pop(8'h69);
        @(negedge i_ref_clk);
        check({15'h0, o_rx_valid_flag}, 16'h0);
        $display("test repeat and abort done");
        i_spi_master_model.xfer(8'hA5, 8, got);
        check({15'h0, o_rx_valid_flag}, 16'h0);
        for (m = 3'h0; m < 3'h2; m = m + 3'h1) begin
            i_serial_mode_select = {2'b01, ~m[0]};
            i_master_select_bit = m[0];
            i_spi_master_model.sel;
            xch(8'h5A, 8'h00, 1'b0);
            check({15'h0, o_miso_oe}, 16'h0);
            i_spi_master_model.desel;
            check({15'h0, o_rx_valid_flag}, 16'h0);
        end
        $display("test mode gate done");
        complete_run;
    end
endmodule // spi_slave_controller_tb
